// ===== rtl/eqc_consts.svh
`ifndef EQC_CONSTS_SVH
`define EQC_CONSTS_SVH
`define EQC_OFS_EYE 12'h000
`define EQC_OFS_PRB1 12'h004
`define EQC_OFS_PRB2 12'h008
`define EQC_OFS_EQSET 12'h00c
`define EQC_OFS_CLOCK_RECOVERY_SETTINGS 12'h010
`define EQC_OFS_AECNT 12'h014
`define EQC_RST_EYE 8'h00
`define EQC_RST_PRB1 8'h00
`define EQC_RST_PRB2 8'h00
`define EQC_RST_EQSET 8'h00
`define EQC_RST_CLOCK_RECOVERY_SETTINGS 8'h9a
`define EQC_EYE_EN_BIT 4
`define EQC_UP_BIT 2
`define EQC_LEAK_BIT 7
`define EQC_NORMAL_LOOP_GAIN_BIT 4
`define EQC_AUX_CODE 4'h8
`define EQC_RD_BASE 10'h040
`endif

// ===== rtl/eqc_pkg.sv
package eqc_pkg;
	typedef enum logic [1:0] {EQC_NORMAL = 2'h0, EQC_SEARCH = 2'h1, EQC_OFF = 2'h2} eqc_mode_t;
	typedef enum logic [2:0]
	{
		EQC_F_ZERO = 3'h0,
		EQC_F_EYE = 3'h1,
		EQC_F_SLICE = 3'h2,
		EQC_F_BCLK = 3'h3,
		EQC_F_FREQ = 3'h4
	} eqc_func_t;
	typedef enum logic [1:0] {EQC_PLL_NORM = 2'h0, EQC_PLL_EXT = 2'h1, EQC_PLL_RET = 2'h3} eqc_pll_t;
endpackage

// ===== rtl/eqc_regs.sv
// Overview of operation
// RQ1: Eye enable low powers the eye DAC down and holds the eye output high.
// RQ2: Eye channel code 0-7 selects main channel, code 1000 selects AUX.
// RQ3: Probe one channel code 0-7 selects main channel, 1000 selects AUX.
// RQ4: Probe one function: zero, digital eye, sliced data, bit clock, PLL frequency.
// RQ5: Probe two channel code 0-7 selects main channel, 1000 selects AUX.
// RQ6: Probe two function: zero, digital eye, sliced data, bit clock, PLL frequency.
// RQ7: Digital eye on a probe is the selected eight-bit two's complement sample.
// RQ8: Sliced data or bit clock on a probe is the present single bit.
// RQ9: PLL frequency on a probe is an eight-bit offset binary word.
// RQ10: Each envelope rising edge steps the counter, up or down by direction bit.
// RQ11: Mode field: 00 normal, 01 search, 10 or 11 off.
// RQ12: Normal mode equalizes all channels and skips envelope processing.
// RQ13: Search mode equalizes only the AUX channel.
// RQ14: Off mode sleeps the equalizer and drives the read sync flag high.
// RQ15: In off mode only the mode settings register is accessible.
// RQ16: Leak bit enables leakage in the PLL loop filter.
// RQ17: Range field sets pull range of 8, 16, 22 or 28 percent.
// RQ18: Range code zero never enters extended range.
// RQ19: Normal gain bit: 0 gives gain 2, 1 gives gain 1.
// RQ20: Extended gain 00-10 gives 2 to 4; software must not program 11.
// RQ21: Return to normal range after 64, 128, 256 or 512 in-range bits.
// RQ22: Software sets search mode before programming the interrupt mask.
// RQ23: The envelope counter is clocked by the one-bit AUX envelope.
// RQ24: Unlisted codes drive the probe low and switch the eye output off.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "eqc_consts.svh"
module eqc_regs
#(
	parameter int ADDR_W = 12
)
(
	// Clock, reset and enable
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Equalizer core samples and strobes
	input wire logic [71:0] chan_eye,
	input wire logic [8:0] chan_slice,
	input wire logic [8:0] chan_bclk,
	input wire logic [7:0] pll_freq,
	input wire logic aux_envelope_bit,
	input wire logic bit_tick,
	input wire logic freq_in_normal,
	input wire logic freq_out_range,
	// Eye DAC
	output logic eye_dac_enable,
	output logic [7:0] eye_dac_data,
	// Probe pins
	output logic [7:0] probe_pin_one,
	output logic [7:0] probe_pin_two,
	// Equalizer and PLL control
	output logic [8:0] chan_eq_en,
	output logic envelope_proc_en,
	output logic eq_sleep,
	output logic read_sync_flag,
	output logic envelope_count_up,
	output logic [15:0] envelope_count,
	output logic loop_leak_enable,
	output logic [1:0] pll_span_sel,
	output logic pll_extended,
	output logic [2:0] pll_gain
);
	import eqc_pkg::*;

	// The highest register offset needs five address bits.
	if (ADDR_W < 5)
	begin
		$error("eqc_regs: ADDR_W too small for the register map.");
	end

	logic rst_s1_r;
	logic rst_n_r;
	logic [7:0] eye_r;
	logic [7:0] prb1_r;
	logic [7:0] prb2_r;
	logic [7:0] eqset_r;
	logic [7:0] clock_recovery_settings_r;
	logic [15:0] cnt_r;
	logic env_d_r;
	eqc_pll_t pll_r;
	logic [9:0] ret_cnt_r;
	logic wr_nxt;
	logic rd_nxt;
	logic blocked;
	logic hit;
	eqc_mode_t mode;

	// Channel code to one-hot; codes above AUX give no channel.
	function automatic logic [8:0] eqc_chan_hot(input logic [3:0] code);
		logic [8:0] h;
		h = 9'h000;
		if (code <= `EQC_AUX_CODE)
			h[code] = 1'b1;
		return h;
	endfunction

	// Probe output for one pin.
	function automatic logic [7:0] eqc_probe(input logic [7:0] sel, input logic [71:0] eye,
		input logic [8:0] slc, input logic [8:0] bck, input logic [7:0] frq);
		logic [7:0] v;
		logic [3:0] c;
		v = 8'h00;
		c = sel[3:0];
		if (c <= `EQC_AUX_CODE) //RQ24
		begin
			case (eqc_func_t'(sel[6:4])) //RQ4 RQ6
				EQC_F_EYE: v = eye[c*8 +: 8]; //RQ7
				EQC_F_SLICE: v = {7'h00, slc[c]}; //RQ8
				EQC_F_BCLK: v = {7'h00, bck[c]}; //RQ8
				EQC_F_FREQ: v = frq; //RQ9
				default: v = 8'h00;
			endcase
		end
		return v;
	endfunction

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	assign mode = eqset_r[1] ? EQC_OFF : eqc_mode_t'(eqset_r[1:0]); //RQ11
	// Off mode locks every register except the mode settings word.
	assign blocked = (mode == EQC_OFF) && (paddr != `EQC_OFS_EQSET); //RQ15
	assign hit = (paddr == `EQC_OFS_EYE) || (paddr == `EQC_OFS_PRB1) ||
		(paddr == `EQC_OFS_PRB2) || (paddr == `EQC_OFS_EQSET) ||
		(paddr == `EQC_OFS_CLOCK_RECOVERY_SETTINGS) || (paddr == `EQC_OFS_AECNT);
	assign wr_nxt = psel && penable && pready && pwrite && hit && !blocked && clk_en;
	assign rd_nxt = psel && !penable && !pwrite;

	// The slave answers one cycle after setup; errors flag unmapped or locked words.
	always_ff @(posedge mclk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && (!hit || blocked); //RQ15
			if (rd_nxt)
			begin
				if (blocked)
					prdata <= 32'h0000_0000;
				else if (paddr == `EQC_OFS_EYE)
					prdata <= {24'h000000, eye_r};
				else if (paddr == `EQC_OFS_PRB1)
					prdata <= {24'h000000, prb1_r};
				else if (paddr == `EQC_OFS_PRB2)
					prdata <= {24'h000000, prb2_r};
				else if (paddr == `EQC_OFS_EQSET)
					prdata <= {24'h000000, eqset_r};
				else if (paddr == `EQC_OFS_CLOCK_RECOVERY_SETTINGS)
					prdata <= {24'h000000, clock_recovery_settings_r};
				else if (paddr == `EQC_OFS_AECNT)
					prdata <= {16'h0000, cnt_r};
				else
					prdata <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			eye_r <= `EQC_RST_EYE;
			prb1_r <= `EQC_RST_PRB1;
			prb2_r <= `EQC_RST_PRB2;
			eqset_r <= `EQC_RST_EQSET;
			clock_recovery_settings_r <= `EQC_RST_CLOCK_RECOVERY_SETTINGS;
		end
		else if (wr_nxt)
		begin
			if (paddr == `EQC_OFS_EYE)
				eye_r <= {3'h0, pwdata[4:0]};
			else if (paddr == `EQC_OFS_PRB1)
				prb1_r <= {1'b0, pwdata[6:0]};
			else if (paddr == `EQC_OFS_PRB2)
				prb2_r <= {1'b0, pwdata[6:0]};
			else if (paddr == `EQC_OFS_EQSET)
				eqset_r <= {5'h00, pwdata[2:0]};
			else if (paddr == `EQC_OFS_CLOCK_RECOVERY_SETTINGS)
				clock_recovery_settings_r <= pwdata[7:0];
		end
	end

	// Envelope counter; a bus load wins over a step in the same cycle.
	always_ff @(posedge mclk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			cnt_r <= 16'h0000;
			env_d_r <= 1'b0;
		end
		else if (clk_en)
		begin
			env_d_r <= aux_envelope_bit; //RQ23
			if (wr_nxt && paddr == `EQC_OFS_AECNT)
				cnt_r <= pwdata[15:0];
			else if (mode == EQC_SEARCH && aux_envelope_bit && !env_d_r) //RQ10 RQ12
				cnt_r <= eqset_r[`EQC_UP_BIT] ? cnt_r + 16'h0001 : cnt_r - 16'h0001; //RQ10
		end
	end

	// PLL range supervisor: return needs a run of in-range bit periods.
	always_ff @(posedge mclk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			pll_r <= EQC_PLL_NORM;
			ret_cnt_r <= 10'h000;
		end
		else if (clk_en)
		begin
			case (pll_r)
				EQC_PLL_NORM:
					if (freq_out_range && clock_recovery_settings_r[6:5] != 2'h0) //RQ18
						pll_r <= EQC_PLL_EXT;
				EQC_PLL_EXT:
					if (clock_recovery_settings_r[6:5] == 2'h0) //RQ18
						pll_r <= EQC_PLL_NORM;
					else if (bit_tick && freq_in_normal)
					begin
						pll_r <= EQC_PLL_RET;
						ret_cnt_r <= 10'h001;
					end
				EQC_PLL_RET:
					if (clock_recovery_settings_r[6:5] == 2'h0)
						pll_r <= EQC_PLL_NORM;
					else if (bit_tick && !freq_in_normal)
						pll_r <= EQC_PLL_EXT;
					else if (bit_tick)
					begin
						if (ret_cnt_r + 10'h001 >= (`EQC_RD_BASE << clock_recovery_settings_r[1:0])) //RQ21
							pll_r <= EQC_PLL_NORM;
						ret_cnt_r <= ret_cnt_r + 10'h001;
					end
				default: pll_r <= EQC_PLL_NORM;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			eye_dac_enable <= 1'b0;
			eye_dac_data <= 8'hff;
			probe_pin_one <= 8'h00;
			probe_pin_two <= 8'h00;
		end
		else if (clk_en)
		begin
			// Unlisted channel codes switch the DAC off as well.
			if (eye_r[`EQC_EYE_EN_BIT] && eye_r[3:0] <= `EQC_AUX_CODE) //RQ1 RQ24
			begin
				eye_dac_enable <= 1'b1;
				eye_dac_data <= chan_eye[eye_r[3:0]*8 +: 8]; //RQ2
			end
			else
			begin
				eye_dac_enable <= 1'b0;
				eye_dac_data <= 8'hff; //RQ1
			end
			probe_pin_one <= eqc_probe(prb1_r, chan_eye, chan_slice, chan_bclk, pll_freq); //RQ3
			probe_pin_two <= eqc_probe(prb2_r, chan_eye, chan_slice, chan_bclk, pll_freq); //RQ5
		end
	end

	always_ff @(posedge mclk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			chan_eq_en <= 9'h000;
			envelope_proc_en <= 1'b0;
			eq_sleep <= 1'b0;
			read_sync_flag <= 1'b0;
			envelope_count_up <= 1'b0;
			envelope_count <= 16'h0000;
			loop_leak_enable <= 1'b1;
			pll_span_sel <= 2'h0;
			pll_extended <= 1'b0;
			pll_gain <= 3'h1;
		end
		else if (clk_en)
		begin
			case (mode)
				EQC_NORMAL: chan_eq_en <= 9'h1ff; //RQ12
				EQC_SEARCH: chan_eq_en <= eqc_chan_hot(`EQC_AUX_CODE); //RQ13
				default: chan_eq_en <= 9'h000;
			endcase
			envelope_proc_en <= (mode == EQC_SEARCH); //RQ12
			eq_sleep <= (mode == EQC_OFF); //RQ14
			read_sync_flag <= (mode == EQC_OFF); //RQ14
			envelope_count_up <= eqset_r[`EQC_UP_BIT];
			envelope_count <= cnt_r;
			loop_leak_enable <= clock_recovery_settings_r[`EQC_LEAK_BIT]; //RQ16
			pll_span_sel <= clock_recovery_settings_r[6:5]; //RQ17
			pll_extended <= (pll_r != EQC_PLL_NORM);
			// Code 11 in the extended gain field is still honoured as gain 5.
			if (pll_r != EQC_PLL_NORM)
				pll_gain <= 3'h2 + {1'b0, clock_recovery_settings_r[3:2]}; //RQ20
			else
				pll_gain <= clock_recovery_settings_r[`EQC_NORMAL_LOOP_GAIN_BIT] ? 3'h1 : 3'h2; //RQ19
		end
	end

	eye_off_a: assert property (@(posedge mclk) disable iff (!rst_n_r) //RQ1
		clk_en && !eye_r[`EQC_EYE_EN_BIT] |=> !eye_dac_enable && eye_dac_data == 8'hff)
		else $error("Eye DAC not off while disabled.");
	sync_off_a: assert property (@(posedge mclk) disable iff (!rst_n_r) //RQ14
		clk_en && eqset_r[1] |=> read_sync_flag && eq_sleep && chan_eq_en == 9'h000)
		else $error("Off mode not entered.");
	lock_off_a: assert property (@(posedge mclk) disable iff (!rst_n_r) //RQ15
		clk_en && mode == EQC_OFF && psel && penable && pready && paddr != `EQC_OFS_EQSET
		|=> $stable({eye_r, prb1_r, prb2_r, clock_recovery_settings_r, cnt_r}))
		else $error("Write accepted in off mode.");
	cnt_step_a: assert property (@(posedge mclk) disable iff (!rst_n_r) //RQ10
		clk_en && mode == EQC_SEARCH && aux_envelope_bit && !env_d_r && !wr_nxt
		|=> cnt_r == $past(cnt_r) + ($past(eqset_r[2]) ? 16'h0001 : 16'hffff))
		else $error("Envelope counter step wrong.");
	cnt_hold_a: assert property (@(posedge mclk) disable iff (!rst_n_r) //RQ12
		mode == EQC_NORMAL && !wr_nxt |=> $stable(cnt_r))
		else $error("Envelope counter moved in normal mode.");
	range_zero_a: assert property (@(posedge mclk) disable iff (!rst_n_r) //RQ18
		clk_en && clock_recovery_settings_r[6:5] == 2'h0 |=> pll_r == EQC_PLL_NORM)
		else $error("Extended range with range code zero.");
	gain_norm_a: assert property (@(posedge mclk) disable iff (!rst_n_r) //RQ19
		clk_en && pll_r == EQC_PLL_NORM |=> pll_gain == ($past(clock_recovery_settings_r[4]) ? 3'h1 : 3'h2))
		else $error("Normal gain wrong.");
	probe_bad_a: assert property (@(posedge mclk) disable iff (!rst_n_r) //RQ24
		clk_en && prb1_r[3:0] > `EQC_AUX_CODE |=> probe_pin_one == 8'h00)
		else $error("Probe not zero for bad channel.");
	search_aux_a: assert property (@(posedge mclk) disable iff (!rst_n_r) //RQ13
		clk_en && mode == EQC_SEARCH |=> chan_eq_en == 9'h100)
		else $error("Search mode channel set wrong.");
endmodule

// ===== verification/eqc_regs_tb.sv
`timescale 1ns/100ps
`include "eqc_consts.svh"
module eqc_regs_tb;
	import eqc_pkg::*;
	logic mclk = 0, reset_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, err;
	logic [71:0] chan_eye = 72'h837363534333231303;
	logic [8:0] chan_slice = 9'h0a5, chan_bclk = 9'h15a, chan_eq_en;
	logic [7:0] pll_freq = 8'hc4, eye_dac_data, probe_pin_one, probe_pin_two;
	logic aux_envelope_bit = 0, bit_tick = 0, freq_in_normal = 0, freq_out_range = 0;
	logic eye_dac_enable, envelope_proc_en, eq_sleep, read_sync_flag, envelope_count_up;
	logic loop_leak_enable, pll_extended;
	logic [15:0] envelope_count;
	logic [1:0] pll_span_sel;
	logic [2:0] pll_gain;
	logic [11:0] ofs [5] = '{`EQC_OFS_EYE, `EQC_OFS_PRB1, `EQC_OFS_PRB2, `EQC_OFS_EQSET,
		`EQC_OFS_CLOCK_RECOVERY_SETTINGS};
	logic [7:0] rv [5] = '{`EQC_RST_EYE, `EQC_RST_PRB1, `EQC_RST_PRB2, `EQC_RST_EQSET,
		`EQC_RST_CLOCK_RECOVERY_SETTINGS};
	int miscompares = 0;
	int comparisons = 0;
	always #2 mclk = ~mclk;
	eqc_regs i_eqc_regs (.mclk, .reset_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .chan_eye, .chan_slice, .chan_bclk, .pll_freq,
		.aux_envelope_bit, .bit_tick, .freq_in_normal, .freq_out_range, .eye_dac_enable,
		.eye_dac_data, .probe_pin_one, .probe_pin_two, .chan_eq_en, .envelope_proc_en, .eq_sleep,
		.read_sync_flag, .envelope_count_up, .envelope_count, .loop_leak_enable, .pll_span_sel,
		.pll_extended, .pll_gain);
	task results;
		if (miscompares == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("BAD %s exp %h got %h", n, e, g);
			miscompares++;
		end
	endtask
	// Starts at the next edge; one idle cycle separates transfers.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
		begin
			miscompares++;
			results();
		end
		else
		begin
			rd = prdata;
			err = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask
	task settle;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task tick(input logic inr, input logic outr, input int n);
		repeat (n)
		begin
			@(posedge mclk);
			bit_tick <= 1;
			freq_in_normal <= inr;
			freq_out_range <= outr;
			@(posedge mclk);
			bit_tick <= 0;
		end
		settle();
	endtask
	task env(input int n);
		repeat (n)
		begin
			@(posedge mclk);
			aux_envelope_bit <= 1;
			repeat (2) @(posedge mclk);
			aux_envelope_bit <= 0;
			@(posedge mclk);
		end
	endtask
	function automatic logic [7:0] pexp(input int f, input int c);
		if (c > 8)
			return 8'h00;
		case (f)
			1: return chan_eye[8*c +: 8];
			2: return {7'h00, chan_slice[c]};
			3: return {7'h00, chan_bclk[c]};
			4: return pll_freq;
			default: return 8'h00;
		endcase
	endfunction
	task t_reset;
		chk("leak", 1, loop_leak_enable);
		chk("gain", 1, pll_gain);
		chk("eyedata", 8'hff, eye_dac_data);
		for (int i = 0; i < 5; i++)
		begin
			apb(0, ofs[i], 0);
			chk("reset", rv[i], rd);
		end
		apb(0, 12'h020, 0);
		chk("unmapped", 1, err);
	endtask
	task t_eye;
		for (int c = 0; c < 10; c++)
		begin
			apb(1, `EQC_OFS_EYE, 32'h10 | c);
			settle();
			chk("eyeen", c < 9, eye_dac_enable);
			chk("eyedata", c < 9 ? chan_eye[8*c +: 8] : 8'hff, eye_dac_data);
		end
		apb(1, `EQC_OFS_EYE, 32'h03);
		settle();
		chk("eyeoff", 0, eye_dac_enable);
		chk("eyehigh", 8'hff, eye_dac_data);
	endtask
	task t_probe;
		int cs [3] = '{3, 8, 9};
		for (int f = 0; f < 6; f++)
			foreach (cs[k])
			begin
				apb(1, `EQC_OFS_PRB1, f * 16 + cs[k]);
				apb(1, `EQC_OFS_PRB2, f * 16 + 11 - cs[k]);
				settle();
				chk("probe1", pexp(f, cs[k]), probe_pin_one);
				chk("probe2", pexp(f, 11 - cs[k]), probe_pin_two);
			end
	endtask
	// Mode 3 is left set, so the eye write below must be dropped.
	task t_mode;
		for (int m = 0; m < 4; m++)
		begin
			apb(1, `EQC_OFS_EQSET, m);
			settle();
			chk("eqen", m == 0 ? 9'h1ff : (m == 1 ? 9'h100 : 9'h000), chan_eq_en);
			chk("envproc", m == 1, envelope_proc_en);
			chk("sleep", m > 1, eq_sleep);
			chk("read_sync_flag", m > 1, read_sync_flag);
			apb(0, `EQC_OFS_EYE, 0);
			chk("eyeerr", m > 1, err);
			apb(0, `EQC_OFS_EQSET, 0);
			chk("modeerr", 0, err);
			chk("modeacc", m, rd);
		end
		apb(1, `EQC_OFS_EYE, 32'h1f);
		apb(1, `EQC_OFS_EQSET, 0);
		apb(0, `EQC_OFS_EYE, 0);
		chk("dropped", 32'h03, rd);
	endtask
	task t_env;
		apb(1, `EQC_OFS_EQSET, 32'h05);
		apb(1, `EQC_OFS_AECNT, 32'h0005);
		settle();
		chk("dirup", 1, envelope_count_up);
		env(3);
		apb(0, `EQC_OFS_AECNT, 0);
		chk("cntup", 32'h0008, rd);
		chk("cntout", 32'h0008, envelope_count);
		apb(1, `EQC_OFS_EQSET, 32'h01);
		env(2);
		apb(0, `EQC_OFS_AECNT, 0);
		chk("cntdn", 32'h0006, rd);
		chk("dirdn", 0, envelope_count_up);
		// An envelope pulse seen only while the enable is low must not count.
		clk_en <= 0;
		env(1);
		clk_en <= 1;
		apb(0, `EQC_OFS_AECNT, 0);
		chk("frozen", 32'h0006, rd);
		apb(1, `EQC_OFS_EQSET, 32'h04);
		env(2);
		apb(0, `EQC_OFS_AECNT, 0);
		chk("cntnorm", 32'h0006, rd);
	endtask
	task t_pll;
		apb(1, `EQC_OFS_CLOCK_RECOVERY_SETTINGS, 0);
		tick(0, 1, 2);
		chk("leakoff", 0, loop_leak_enable);
		chk("gnor0", 2, pll_gain);
		chk("noext", 0, pll_extended);
		for (int g = 0; g < 4; g++)
		begin
			apb(1, `EQC_OFS_CLOCK_RECOVERY_SETTINGS, 32'h20 | ((g % 3) << 2) | g);
			tick(0, 1, 1);
			chk("span", 1, pll_span_sel);
			chk("ext", 1, pll_extended);
			chk("extgain", g % 3 + 2, pll_gain);
			tick(1, 0, (64 << g) - 1);
			chk("stay", 1, pll_extended);
			tick(1, 0, 1);
			chk("back", 0, pll_extended);
			chk("normgain", 2, pll_gain);
		end
	endtask
	initial
	begin
		repeat (4) @(posedge mclk);
		reset_n <= 1;
		repeat (3) @(posedge mclk);
		#1;
		t_reset();
		t_eye();
		t_probe();
		t_mode();
		t_env();
		t_pll();
		results();
	end
endmodule
